// *** inc/drive_status_pkg.sv ***
// Constants, field positions and types shared by the status and alarm reporting block.
package drive_status_pkg;

   localparam int WORD_W = 16;

   // Status word bit positions.
   localparam int ST_MOTOR_ENABLED = 0;
   localparam int ST_SAMPLING      = 1;
   localparam int ST_DRIVE_FAULT   = 2;
   localparam int ST_IN_POSITION   = 3;
   localparam int ST_MOVING        = 4;
   localparam int ST_JOGGING       = 5;
   localparam int ST_STOPPING      = 6;
   localparam int ST_WAIT_INPUT    = 7;
   localparam int ST_SAVING        = 8;
   localparam int ST_ALARM_PRESENT = 9;
   localparam int ST_HOMING        = 10;
   localparam int ST_WAIT_TIME     = 11;
   localparam int ST_WIZARD        = 12;
   localparam int ST_ENCODER_CHECK = 13;
   localparam int ST_PROGRAM       = 14;
   localparam int ST_INITIALIZING  = 15;

   // Alarm word bit positions.
   localparam int AL_POSITION_LIMIT = 0;
   localparam int AL_CCW_LIMIT      = 1;
   localparam int AL_CW_LIMIT       = 2;
   localparam int AL_OVER_TEMP      = 3;
   localparam int AL_OVER_VOLTAGE   = 5;
   localparam int AL_UNDER_VOLTAGE  = 6;
   localparam int AL_OVER_CURRENT   = 7;
   localparam int AL_BAD_HALL       = 8;
   localparam int AL_BAD_ENCODER    = 9;
   localparam int AL_COMM_ERROR     = 10;
   localparam int AL_BAD_FLASH      = 11;
   localparam int AL_CURRENT_LIMIT  = 13;
   localparam int AL_NO_MOVE        = 15;

   // Alarms that disable the motor.
   localparam logic [15:0] DRIVE_FAULT_MASK = 16'h0bf8;
   localparam logic [15:0] WORD_RESET       = 16'h0000;

   typedef enum logic [1:0]
   {
      alarm_query_command         = 2'h0,
      state_query_command         = 2'h1,
      read_alarm_register_command = 2'h2,
      read_state_register_command = 2'h3
   } query_t;

   // Text conversion.
   localparam int          DIGITS      = 5;
   localparam logic [4:0]  CONV_LAST   = 5'h0f;
   localparam logic [3:0]  DEC_LIMIT   = 4'h5;
   localparam logic [3:0]  DEC_ADJUST  = 4'h3;
   localparam logic [3:0]  HEX_LIMIT   = 4'ha;
   localparam logic [7:0]  ASCII_ZERO  = 8'h30;
   localparam logic [7:0]  ASCII_ALPHA = 8'h37;

   // Front LED code table: alarm bit, first count, second count, in priority order.
   localparam int LED_CODES = 13;
   localparam logic [3:0] LED_BIT [0:LED_CODES-1] = '{4'h0, 4'hf, 4'h1, 4'h2, 4'h3, 4'hb,
      4'h5, 4'h6, 4'h7, 4'hd, 4'h8, 4'h9, 4'ha};
   localparam logic [2:0] LED_FIRST [0:LED_CODES-1] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3,
      3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7};
   localparam logic [2:0] LED_SECOND [0:LED_CODES-1] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h2,
      3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1};

   typedef enum logic [1:0]
   {
      led_solid = 2'h0,
      led_slow  = 2'h1,
      led_fast  = 2'h2,
      led_code  = 2'h3
   } led_mode_t;

   // LED timing.
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
   localparam int unsigned LED_SLOW_MS  = 500;
   localparam int unsigned LED_FAST_MS  = 100;
   localparam int unsigned LED_PULSE_MS = 250;
   localparam int unsigned LED_GAP_MS   = 750;
   localparam int unsigned LED_PAUSE_MS = 2000;
   localparam logic [31:0] TIMER_ZERO   = 32'h0000_0000;
   localparam logic [31:0] TIMER_STEP   = 32'h0000_0001;

endpackage

// *** hdl/led_flash_coder.sv ***
// Front LED driver: solid, slow or fast blink, or a repeating pair of flash counts.
`timescale 1ns/10ps
`default_nettype none
module led_flash_coder
#(
   parameter logic [31:0] SLOW_HALF_CYC = 32'd20_000_000,
   parameter logic [31:0] FAST_HALF_CYC = 32'd4_000_000,
   parameter logic [31:0] PULSE_CYC     = 32'd10_000_000,
   parameter logic [31:0] GAP_CYC       = 32'd30_000_000,
   parameter logic [31:0] PAUSE_CYC     = 32'd80_000_000
)
(
   // Clock and reset.
   input  wire logic                        sys_clk,
   input  wire logic                        rst_b,
   // Requested display.
   input  wire drive_status_pkg::led_mode_t mode,
   input  wire logic [2:0]                  first_count,
   input  wire logic [2:0]                  second_count,
   // LED drive.
   output logic                             led_on
);

   typedef enum logic [4:0]
   {
      ls_steady = 5'b00001,
      ls_on     = 5'b00010,
      ls_off    = 5'b00100,
      ls_gap    = 5'b01000,
      ls_pause  = 5'b10000
   } led_state_t;

   led_state_t  state_reg, state_next;
   logic [31:0] timer_reg, timer_next;
   logic [2:0]  pulses_reg, pulses_next;
   logic [2:0]  second_reg, second_next;
   logic        in_second_reg, in_second_next;
   logic        led_reg, led_next;
   logic [31:0] half;

   always_comb
   begin
      state_next     = state_reg;
      timer_next     = timer_reg + drive_status_pkg::TIMER_STEP;
      pulses_next    = pulses_reg;
      second_next    = second_reg;
      in_second_next = in_second_reg;
      led_next       = led_reg;
      half           = (mode == drive_status_pkg::led_fast) ? FAST_HALF_CYC : SLOW_HALF_CYC;
      unique case (state_reg)
         ls_steady:
         begin
            if (mode == drive_status_pkg::led_solid)
            begin
               led_next   = 1'b1;
               timer_next = drive_status_pkg::TIMER_ZERO;
            end
            else if (mode == drive_status_pkg::led_code)
            begin
               state_next     = ls_on;
               led_next       = 1'b1;
               timer_next     = drive_status_pkg::TIMER_ZERO;
               pulses_next    = first_count;
               second_next    = second_count;
               in_second_next = 1'b0;
            end
            else if (timer_reg >= half - drive_status_pkg::TIMER_STEP)
            begin
               led_next   = ~led_reg;
               timer_next = drive_status_pkg::TIMER_ZERO;
            end
         end
         ls_on:
         begin
            if (timer_reg == PULSE_CYC - drive_status_pkg::TIMER_STEP)
            begin
               state_next = ls_off;
               led_next   = 1'b0;
               timer_next = drive_status_pkg::TIMER_ZERO;
            end
         end
         ls_off:
         begin
            if (timer_reg == PULSE_CYC - drive_status_pkg::TIMER_STEP)
            begin
               timer_next = drive_status_pkg::TIMER_ZERO;
               if (pulses_reg > 3'h1)
               begin
                  pulses_next = pulses_reg - 3'h1;
                  state_next  = ls_on;
                  led_next    = 1'b1;
               end
               else if (!in_second_reg)
               begin
                  in_second_next = 1'b1;
                  pulses_next    = second_reg;
                  state_next     = ls_gap;
               end
               else
               begin
                  state_next = ls_pause;
               end
            end
         end
         ls_gap:
         begin
            if (timer_reg == GAP_CYC - drive_status_pkg::TIMER_STEP)
            begin
               state_next = ls_on;
               led_next   = 1'b1;
               timer_next = drive_status_pkg::TIMER_ZERO;
            end
         end
         ls_pause:
         begin
            if (timer_reg == PAUSE_CYC - drive_status_pkg::TIMER_STEP)
            begin
               state_next = ls_steady;
               timer_next = drive_status_pkg::TIMER_ZERO;
            end
         end
         default:
         begin
            state_next = ls_steady;
         end
      endcase
      if (state_reg != ls_steady && mode != drive_status_pkg::led_code)
      begin
         state_next = ls_steady;
         timer_next = drive_status_pkg::TIMER_ZERO;
         led_next   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg     <= ls_steady;
         timer_reg     <= drive_status_pkg::TIMER_ZERO;
         pulses_reg    <= 3'h0;
         second_reg    <= 3'h0;
         in_second_reg <= 1'b0;
         led_reg       <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         timer_reg     <= timer_next;
         pulses_reg    <= pulses_next;
         second_reg    <= second_next;
         in_second_reg <= in_second_next;
         led_reg       <= led_next;
      end
   end

   assign led_on = led_reg;

endmodule
`default_nettype wire

// *** hdl/drive_status_alarm_reporting.sv ***
// Drive status and alarm words, their text replies to host queries, and the front LED code.
`timescale 1ns/10ps
`default_nettype none
module drive_status_alarm_reporting
#(
   parameter logic [31:0] SLOW_HALF_CYC = 32'(drive_status_pkg::LED_SLOW_MS *
                                              drive_status_pkg::CYC_PER_MS),
   parameter logic [31:0] FAST_HALF_CYC = 32'(drive_status_pkg::LED_FAST_MS *
                                              drive_status_pkg::CYC_PER_MS),
   parameter logic [31:0] PULSE_CYC     = 32'(drive_status_pkg::LED_PULSE_MS *
                                              drive_status_pkg::CYC_PER_MS),
   parameter logic [31:0] GAP_CYC       = 32'(drive_status_pkg::LED_GAP_MS *
                                              drive_status_pkg::CYC_PER_MS),
   parameter logic [31:0] PAUSE_CYC     = 32'(drive_status_pkg::LED_PAUSE_MS *
                                              drive_status_pkg::CYC_PER_MS)
)
(
   // Clock and reset.
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   // Drive conditions.
   input  wire logic                     enable_request,
   input  wire logic                     tuning_sampling,
   input  wire logic                     in_position,
   input  wire logic                     moving,
   input  wire logic                     jogging,
   input  wire logic                     stopping,
   input  wire logic                     wait_input_instruction,
   input  wire logic                     saving,
   input  wire logic                     seek_home_instruction,
   input  wire logic                     wait_time_instruction,
   input  wire logic                     wizard_running,
   input  wire logic                     encoder_check_running,
   input  wire logic                     program_running,
   input  wire logic                     init_done,
   // Alarm events and clear.
   input  wire logic [15:0]              alarm_event,
   input  wire logic                     alarm_clear,
   // Host query.
   input  wire logic                     cmd_valid,
   input  wire drive_status_pkg::query_t cmd_code,
   output logic                          cmd_busy,
   // Reply text.
   output logic                          reply_valid,
   output logic [7:0]                    reply_char,
   output logic                          reply_last,
   input  wire logic                     reply_ready,
   // Words and drive outputs.
   output logic [15:0]                   alarm_word,
   output logic [15:0]                   status_word,
   output logic                          motor_enable,
   output logic                          led_on
);

   typedef enum logic [3:0]
   {
      st_idle = 4'b0001,
      st_conv = 4'b0010,
      st_load = 4'b0100,
      st_emit = 4'b1000
   } reply_state_t;

   logic [15:0] alarm_reg, alarm_next;
   logic [15:0] status_reg, status_next;
   logic        init_reg, init_next;
   logic        enable_reg, enable_next;
   logic        fault;

   function automatic logic [7:0] to_ascii(input logic [3:0] d);
      logic [7:0] c;
      c = (d < drive_status_pkg::HEX_LIMIT) ? drive_status_pkg::ASCII_ZERO
                                            : drive_status_pkg::ASCII_ALPHA;
      return c + {4'h0, d};
   endfunction

   // Word state.
   always_comb
   begin
      alarm_next  = (alarm_reg & ~{16{alarm_clear}}) | alarm_event;
      init_next   = init_reg & ~init_done;
      fault       = |(alarm_reg & drive_status_pkg::DRIVE_FAULT_MASK);
      enable_next = enable_request & ~fault & ~init_reg;
      status_next = drive_status_pkg::WORD_RESET;
      status_next[drive_status_pkg::ST_MOTOR_ENABLED] = enable_reg;
      status_next[drive_status_pkg::ST_SAMPLING]      = tuning_sampling;
      status_next[drive_status_pkg::ST_DRIVE_FAULT]   = fault;
      status_next[drive_status_pkg::ST_IN_POSITION]   = in_position;
      status_next[drive_status_pkg::ST_MOVING]        = moving;
      status_next[drive_status_pkg::ST_JOGGING]       = jogging;
      status_next[drive_status_pkg::ST_STOPPING]      = stopping;
      status_next[drive_status_pkg::ST_WAIT_INPUT]    = wait_input_instruction;
      status_next[drive_status_pkg::ST_SAVING]        = saving;
      status_next[drive_status_pkg::ST_ALARM_PRESENT] = |alarm_reg;
      status_next[drive_status_pkg::ST_HOMING]        = seek_home_instruction;
      status_next[drive_status_pkg::ST_WAIT_TIME]     = wait_time_instruction;
      status_next[drive_status_pkg::ST_WIZARD]        = wizard_running;
      status_next[drive_status_pkg::ST_ENCODER_CHECK] = encoder_check_running;
      status_next[drive_status_pkg::ST_PROGRAM]       = program_running;
      status_next[drive_status_pkg::ST_INITIALIZING]  = init_reg;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         alarm_reg  <= drive_status_pkg::WORD_RESET;
         status_reg <= drive_status_pkg::WORD_RESET;
         init_reg   <= 1'b1;
         enable_reg <= 1'b0;
      end
      else
      begin
         alarm_reg  <= alarm_next;
         status_reg <= status_next;
         init_reg   <= init_next;
         enable_reg <= enable_next;
      end
   end

   // Reply state.
   reply_state_t state_reg, state_next;
   logic [19:0]  digits_reg, digits_next;
   logic [15:0]  shift_reg, shift_next;
   logic [4:0]   count_reg, count_next;
   logic [2:0]   index_reg, index_next;
   logic         busy_reg, busy_next;
   logic         valid_reg, valid_next;
   logic         last_reg, last_next;
   logic [7:0]   char_reg, char_next;
   logic [15:0]  word;
   logic [19:0]  adj;
   logic [2:0]   lead;
   logic [2:0]   down;

   always_comb
   begin
      state_next  = state_reg;
      digits_next = digits_reg;
      shift_next  = shift_reg;
      count_next  = count_reg;
      index_next  = index_reg;
      valid_next  = valid_reg;
      last_next   = last_reg;
      char_next   = char_reg;
      adj         = digits_reg;
      lead        = 3'h0;
      down        = index_reg - 3'h1;
      word        = (cmd_code == drive_status_pkg::alarm_query_command ||
                     cmd_code == drive_status_pkg::read_alarm_register_command)
                    ? alarm_reg : status_reg;
      for (int i = 0; i < drive_status_pkg::DIGITS; i++)
      begin
         if (adj[i*4 +: 4] >= drive_status_pkg::DEC_LIMIT)
         begin
            adj[i*4 +: 4] = adj[i*4 +: 4] + drive_status_pkg::DEC_ADJUST;
         end
         if (digits_reg[i*4 +: 4] != 4'h0)
         begin
            lead = 3'(i);
         end
      end
      unique case (state_reg)
         st_idle:
         begin
            if (cmd_valid)
            begin
               count_next = 5'h00;
               if (cmd_code == drive_status_pkg::alarm_query_command ||
                   cmd_code == drive_status_pkg::state_query_command)
               begin
                  digits_next = {4'h0, word};
                  state_next  = st_load;
               end
               else
               begin
                  digits_next = 20'h00000;
                  shift_next  = word;
                  state_next  = st_conv;
               end
            end
         end
         st_conv:
         begin
            digits_next = {adj[18:0], shift_reg[15]};
            shift_next  = {shift_reg[14:0], 1'b0};
            count_next  = count_reg + 5'h01;
            if (count_reg == drive_status_pkg::CONV_LAST)
            begin
               state_next = st_load;
            end
         end
         st_load:
         begin
            index_next = lead;
            char_next  = to_ascii(digits_reg[lead*4 +: 4]);
            last_next  = (lead == 3'h0);
            valid_next = 1'b1;
            state_next = st_emit;
         end
         st_emit:
         begin
            if (reply_ready)
            begin
               if (index_reg == 3'h0)
               begin
                  valid_next = 1'b0;
                  last_next  = 1'b0;
                  state_next = st_idle;
               end
               else
               begin
                  index_next = down;
                  char_next  = to_ascii(digits_reg[down*4 +: 4]);
                  last_next  = (down == 3'h0);
               end
            end
         end
         default:
         begin
            state_next = st_idle;
            valid_next = 1'b0;
            last_next  = 1'b0;
         end
      endcase
      busy_next = (state_next != st_idle);
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg  <= st_idle;
         digits_reg <= 20'h00000;
         shift_reg  <= 16'h0000;
         count_reg  <= 5'h00;
         index_reg  <= 3'h0;
         busy_reg   <= 1'b0;
         valid_reg  <= 1'b0;
         last_reg   <= 1'b0;
         char_reg   <= 8'h00;
      end
      else
      begin
         state_reg  <= state_next;
         digits_reg <= digits_next;
         shift_reg  <= shift_next;
         count_reg  <= count_next;
         index_reg  <= index_next;
         busy_reg   <= busy_next;
         valid_reg  <= valid_next;
         last_reg   <= last_next;
         char_reg   <= char_next;
      end
   end

   // LED selection: lowest listed active alarm wins.
   drive_status_pkg::led_mode_t mode_reg, mode_next;
   logic [2:0] first_reg, first_next;
   logic [2:0] second_reg, second_next;

   always_comb
   begin
      first_next  = 3'h0;
      second_next = 3'h0;
      mode_next   = program_running ? drive_status_pkg::led_fast :
                    (enable_reg ? drive_status_pkg::led_slow
                                : drive_status_pkg::led_solid);
      for (int i = drive_status_pkg::LED_CODES - 1; i >= 0; i--)
      begin
         if (alarm_reg[drive_status_pkg::LED_BIT[i]])
         begin
            mode_next   = drive_status_pkg::led_code;
            first_next  = drive_status_pkg::LED_FIRST[i];
            second_next = drive_status_pkg::LED_SECOND[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_reg   <= drive_status_pkg::led_solid;
         first_reg  <= 3'h0;
         second_reg <= 3'h0;
      end
      else
      begin
         mode_reg   <= mode_next;
         first_reg  <= first_next;
         second_reg <= second_next;
      end
   end

   led_flash_coder
   #(
      .SLOW_HALF_CYC (SLOW_HALF_CYC),
      .FAST_HALF_CYC (FAST_HALF_CYC),
      .PULSE_CYC     (PULSE_CYC),
      .GAP_CYC       (GAP_CYC),
      .PAUSE_CYC     (PAUSE_CYC)
   )
   u_led
   (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .mode         (mode_reg),
      .first_count  (first_reg),
      .second_count (second_reg),
      .led_on       (led_on)
   );

   assign alarm_word   = alarm_reg;
   assign status_word  = status_reg;
   assign motor_enable = enable_reg;
   assign cmd_busy     = busy_reg;
   assign reply_valid  = valid_reg;
   assign reply_char   = char_reg;
   assign reply_last   = last_reg;

endmodule
`default_nettype wire

// *** tb/drive_status_checker_assertions.sv ***
// Port checks for the status and alarm reporting block.
`timescale 1ns/10ps
`default_nettype none
module drive_status_checker
(
   input wire logic                     sys_clk,
   input wire logic                     rst_b,
   input wire logic                     cmd_valid,
   input wire drive_status_pkg::query_t cmd_code,
   input wire logic                     cmd_busy,
   input wire logic                     reply_valid,
   input wire logic [7:0]               reply_char,
   input wire logic                     reply_last,
   input wire logic                     reply_ready,
   input wire logic [15:0]              alarm_event,
   input wire logic                     alarm_clear,
   input wire logic [15:0]              alarm_word,
   input wire logic [15:0]              status_word,
   input wire logic                     motor_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic acc;
   logic flt;
   assign acc = cmd_valid && !cmd_busy && !reply_valid;
   assign flt = |(alarm_word & drive_status_pkg::DRIVE_FAULT_MASK);
   a_reply_holds: assert property (reply_valid && !reply_ready |=> reply_valid
      && $stable(reply_char) && $stable(reply_last)) else $error("Reply moved early.");
   a_hex_answer: assert property (acc && !cmd_code[1] |=> cmd_busy ##1 reply_valid)
      else $error("Hex reply late.");
   a_dec_answer: assert property (acc && cmd_code[1] |-> ##17 !reply_valid ##1 reply_valid)
      else $error("Decimal reply late.");
   a_fault_bit: assert property (status_word[2] == $past(flt))
      else $error("Fault bit wrong.");
   a_alarm_bit: assert property (status_word[9] == $past(|alarm_word))
      else $error("Alarm bit wrong.");
   a_fault_disables: assert property (flt |=> !motor_enable)
      else $error("Motor stayed enabled.");
   a_enable_bit: assert property (status_word[0] == $past(motor_enable))
      else $error("Enable bit wrong.");
   a_alarm_sticky: assert property (alarm_word == (($past(alarm_word)
      & ~{16{$past(alarm_clear)}}) | $past(alarm_event))) else $error("Alarm word wrong.");
   c_hex: cover property (acc && !cmd_code[1]);
   c_dec: cover property (acc && cmd_code[1]);
   c_stall: cover property (reply_valid && !reply_ready);
   c_fault: cover property (flt);
endmodule
bind drive_status_alarm_reporting drive_status_checker u_chk (.sys_clk, .rst_b, .cmd_valid,
   .cmd_code, .cmd_busy, .reply_valid, .reply_char, .reply_last, .reply_ready, .alarm_event,
   .alarm_clear, .alarm_word, .status_word, .motor_enable);
`default_nettype wire

// *** tb/query_host.sv ***
// Host model: takes reply characters, gathers them as text, can stall.
`timescale 1ns/10ps
`default_nettype none
module query_host
(
   // Clock.
   input  wire logic       sys_clk,
   // Reply stream.
   input  wire logic       reply_valid,
   input  wire logic [7:0] reply_char,
   input  wire logic       reply_last,
   output logic            reply_ready,
   // Control.
   input  wire logic       stall
);
   string text = "";
   logic  done = 1'b0;
   always @(negedge sys_clk) reply_ready <= stall ? ~reply_ready : 1'b1;
   always @(posedge sys_clk)
   begin
      if (reply_valid && reply_ready)
      begin
         text = {text, string'(reply_char)};
         done = reply_last;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench for the status and alarm reporting block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0, rst_b = 1'b0, en = 1'b0, init_done = 1'b0, clr = 1'b0;
   logic cmd_valid = 1'b0, stall = 1'b0, busy, rv, rl, rr, men, led_on;
   logic [11:0] cond = 12'h000;
   logic [15:0] ev = 16'h0000, aw, sw;
   logic [7:0] rc;
   drive_status_pkg::query_t code = drive_status_pkg::alarm_query_command;
   int mismatches = 0, total_checks = 0, cycles = 0, lit, rises;
   int pos [12] = '{1, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14};
   always #12.5 sys_clk = ~sys_clk;
   drive_status_alarm_reporting #(.SLOW_HALF_CYC(32'h8), .FAST_HALF_CYC(32'h4),
      .PULSE_CYC(32'h3), .GAP_CYC(32'h5), .PAUSE_CYC(32'h7)) u_dut (.sys_clk, .rst_b,
      .enable_request(en), .tuning_sampling(cond[0]), .in_position(cond[1]),
      .moving(cond[2]), .jogging(cond[3]), .stopping(cond[4]),
      .wait_input_instruction(cond[5]), .saving(cond[6]), .seek_home_instruction(cond[7]),
      .wait_time_instruction(cond[8]), .wizard_running(cond[9]),
      .encoder_check_running(cond[10]), .program_running(cond[11]), .init_done,
      .alarm_event(ev), .alarm_clear(clr), .cmd_valid, .cmd_code(code), .cmd_busy(busy),
      .reply_valid(rv), .reply_char(rc), .reply_last(rl), .reply_ready(rr),
      .alarm_word(aw), .status_word(sw), .motor_enable(men), .led_on);
   query_host h (.sys_clk, .reply_valid(rv), .reply_char(rc), .reply_last(rl),
      .reply_ready(rr), .stall);
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_text(input string exp);
      total_checks++;
      if (h.text != exp)
      begin
         mismatches++;
         $display("ERROR reply expected %s seen %s", exp, h.text);
      end
   endtask
   task automatic query(input drive_status_pkg::query_t c, input string exp);
      int n;
      h.text = "";
      h.done = 1'b0;
      code = c;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      check("busy", 16'h0001, {15'h0000, busy});
      n = 0;
      while (h.done !== 1'b1 && n < 100)
      begin
         @(negedge sys_clk);
         n++;
      end
      check("last", 16'h0001, {15'h0000, h.done});
      check_text(exp);
   endtask
   task automatic pulse_alarm(input logic [15:0] e, input logic c);
      ev = e;
      clr = c;
      @(negedge sys_clk);
      ev = 16'h0000;
      clr = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic led_watch(input int cyc);
      logic p;
      p = led_on;
      lit = 0;
      rises = 0;
      repeat (cyc)
      begin
         @(negedge sys_clk);
         lit += (led_on === 1'b1);
         rises += (led_on === 1'b1 && p === 1'b0);
         p = led_on;
      end
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (6) @(negedge sys_clk);
      rst_b = 1'b1;
      @(negedge sys_clk);
      check("status", 16'h8000, sw);
      init_done = 1'b1;
      @(negedge sys_clk);
      init_done = 1'b0;
      repeat (3) @(negedge sys_clk);
      check("status", 16'h0000, sw);
      led_watch(16);
      check("led lit", 16'd16, 16'(lit));
      for (int i = 0; i < 12; i++)
      begin
         cond = 12'h001 << i;
         repeat (2) @(negedge sys_clk);
         check("status", 16'h0001 << pos[i], sw);
      end
      cond = 12'h822;
      repeat (2) @(negedge sys_clk);
      check("status", 16'h4088, sw);
      query(drive_status_pkg::state_query_command, "4088");
      query(drive_status_pkg::read_state_register_command, "16520");
      cond = 12'h000;
      en = 1'b1;
      repeat (3) @(negedge sys_clk);
      check("status", 16'h0001, sw);
      check("motor", 16'h0001, {15'h0000, men});
      led_watch(16);
      check("led lit", 16'd8, 16'(lit));
      pulse_alarm(16'h0244, 1'b0);
      check("alarm", 16'h0244, aw);
      check("status", 16'h0204, sw);
      check("motor", 16'h0000, {15'h0000, men});
      stall = 1'b1;
      query(drive_status_pkg::alarm_query_command, "244");
      query(drive_status_pkg::read_alarm_register_command, "580");
      stall = 1'b0;
      pulse_alarm(16'hffff, 1'b0);
      query(drive_status_pkg::alarm_query_command, "FFFF");
      query(drive_status_pkg::read_alarm_register_command, "65535");
      pulse_alarm(16'h0000, 1'b1);
      query(drive_status_pkg::alarm_query_command, "0");
      pulse_alarm(16'h0004, 1'b0);
      repeat (80) @(negedge sys_clk);
      led_watch(37);
      check("led pair", 16'd4, 16'(rises));
      pulse_alarm(16'h0400, 1'b1);
      repeat (80) @(negedge sys_clk);
      led_watch(61);
      check("led pair", 16'd8, 16'(rises));
      give_verdict();
   end
endmodule
`default_nettype wire
